// File: rtl/hdm_pkg.sv
`default_nettype none
package hdm_pkg;
   // ========================================
   // Timing
   localparam int unsigned CLK_HZ        = 20000000;
   localparam int unsigned CYCLE_MS      = 5;
   localparam int unsigned CYCLE_CLKS    = CLK_HZ / 1000 * CYCLE_MS;
   localparam int unsigned STEP_MS       = 5;
   localparam logic [18:0] DELAY_DEFAULT = 19'h007d0;
   localparam logic [18:0] DELAY_MAX     = 19'h57e40;
   localparam int unsigned RELEASE_PCT   = 97;
   localparam int unsigned LOG_DEPTH     = 12;
   localparam logic [15:0] PICKUP_DEFAULT = 16'h03e8;

   // ========================================
   // Group indices
   localparam int unsigned GRP_PHASE = 0;
   localparam int unsigned GRP_RES1  = 1;
   localparam int unsigned GRP_RES2  = 2;

   // ========================================
   // Event codes
   typedef enum logic [3:0] {
      EV_START_PH_ON  = 4'h0, EV_START_PH_OFF = 4'h1,
      EV_START_R1_ON  = 4'h2, EV_START_R1_OFF = 4'h3,
      EV_START_R2_ON  = 4'h4, EV_START_R2_OFF = 4'h5,
      EV_ALARM_PH_ON  = 4'h6, EV_ALARM_PH_OFF = 4'h7,
      EV_ALARM_R1_ON  = 4'h8, EV_ALARM_R1_OFF = 4'h9,
      EV_ALARM_R2_ON  = 4'ha, EV_ALARM_R2_OFF = 4'hb,
      EV_BLOCKED_ON   = 4'hc, EV_BLOCKED_OFF  = 4'hd
   } hdm_event_t;

   // Monitor state
   typedef enum logic [1:0] {
      ST_NORMAL  = 2'b00,
      ST_START   = 2'b01,
      ST_ALARM   = 2'b10,
      ST_BLOCKED = 2'b11
   } hdm_state_t;

   // ========================================
   // Carriers
   typedef struct packed {
      logic [15:0] thdL1;
      logic [15:0] thdL2;
      logic [15:0] thdL3;
      logic [15:0] thdRes1;
      logic [15:0] thdRes2;
   } hdm_meas_t;

   typedef struct packed {
      logic [47:0] stamp;
      hdm_event_t  code;
      logic [15:0] thdL1;
      logic [15:0] thdL2;
      logic [15:0] thdL3;
      logic [2:0]  setGroup;
   } hdm_log_t;

   typedef struct packed {
      logic [47:0] stamp;
      hdm_event_t  code;
   } hdm_evt_t;
endpackage : hdm_pkg
`default_nettype wire

// File: rtl/hdm_monitor.sv
`default_nettype none
module hdm_monitor #(
   parameter int unsigned CycleClks = hdm_pkg::CYCLE_CLKS
) (
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire logic              blockIn,
   input  wire hdm_pkg::hdm_meas_t measAmpl,
   input  wire hdm_pkg::hdm_meas_t measPower,
   input  wire logic              usePower,
   input  wire logic [2:0]        enable,
   input  wire logic [15:0]       pickupPhase,
   input  wire logic [15:0]       pickupRes1,
   input  wire logic [15:0]       pickupRes2,
   input  wire logic [18:0]       delayPhase,
   input  wire logic [18:0]       delayRes1,
   input  wire logic [18:0]       delayRes2,
   input  wire logic [13:0]       selOn,
   input  wire logic [13:0]       selOff,
   input  wire logic [47:0]       timeNow,
   input  wire logic [2:0]        setGroup,
   input  wire logic              counterClear,
   input  wire logic [3:0]        logIndex,
   input  wire logic              evtReady,
   output logic [2:0]             startOut,
   output logic [2:0]             alarmOut,
   output logic                   blockedOut,
   output hdm_pkg::hdm_state_t    status,
   output logic                   evtValid,
   output hdm_pkg::hdm_evt_t      evtData,
   output logic [15:0]            startCount,
   output logic [15:0]            alarmCount,
   output logic [15:0]            blockedCount,
   output hdm_pkg::hdm_log_t      logData,
   output logic [3:0]             logFill,
   output logic                   cycleTick
);
   // ========================================
   // Processing cycle tick
   logic [16:0] cycCnt_r, cycCnt_nxt;
   logic        tick_r, tick_nxt;

   always_comb begin
      tick_nxt = 1'b0;
      cycCnt_nxt = cycCnt_r + 17'h00001;
      if (cycCnt_r == 17'(CycleClks - 1)) begin
         cycCnt_nxt = 17'h00000;
         tick_nxt = 1'b1;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cycCnt_r <= 17'h00000;
         tick_r <= 1'b0;
      end else begin
         cycCnt_r <= cycCnt_nxt;
         tick_r <= tick_nxt;
      end
   end

   // ========================================
   // Pick-up with hysteresis
   function automatic logic over_set(input logic [15:0] v, input logic [15:0] s);
      over_set = v > s;
   endfunction : over_set

   function automatic logic under_rel(input logic [15:0] v, input logic [15:0] s);
      under_rel = (32'(v) * 32'd100) < (32'(s) * 32'(hdm_pkg::RELEASE_PCT));
   endfunction : under_rel

   hdm_pkg::hdm_meas_t meas;
   logic [2:0]         pickup_r, pickup_nxt;
   logic [2:0]         overAny, underAll;

   always_comb begin
      meas = usePower ? measPower : measAmpl;
      overAny[hdm_pkg::GRP_PHASE] = over_set(meas.thdL1, pickupPhase) | over_set(meas.thdL2, pickupPhase)
                                  | over_set(meas.thdL3, pickupPhase);
      underAll[hdm_pkg::GRP_PHASE] = under_rel(meas.thdL1, pickupPhase) & under_rel(meas.thdL2, pickupPhase)
                                   & under_rel(meas.thdL3, pickupPhase);
      overAny[hdm_pkg::GRP_RES1] = over_set(meas.thdRes1, pickupRes1);
      underAll[hdm_pkg::GRP_RES1] = under_rel(meas.thdRes1, pickupRes1);
      overAny[hdm_pkg::GRP_RES2] = over_set(meas.thdRes2, pickupRes2);
      underAll[hdm_pkg::GRP_RES2] = under_rel(meas.thdRes2, pickupRes2);
      pickup_nxt = pickup_r;
      if (tick_r) begin
         pickup_nxt = enable & ((pickup_r & ~underAll) | overAny);
      end
   end

   // ========================================
   // Group state, timers
   logic        blk_r, blk_nxt;
   logic [2:0]  start_r, start_nxt, alarm_r, alarm_nxt, blocked_r, blocked_nxt;
   logic [18:0] tmr_r [3], tmr_nxt [3];
   logic [18:0] dly [3];

   always_comb begin
      dly[0] = delayPhase;
      dly[1] = delayRes1;
      dly[2] = delayRes2;
      blk_nxt = tick_r ? blockIn : blk_r;
      start_nxt = start_r;
      alarm_nxt = alarm_r;
      blocked_nxt = blocked_r;
      for (int g = 0; g < 3; g++) begin
         tmr_nxt[g] = tmr_r[g];
         if (tick_r) begin
            if (pickup_nxt[g] && !blk_nxt) begin
               start_nxt[g] = 1'b1;
               blocked_nxt[g] = 1'b0;
               if (start_r[g] && tmr_r[g] < dly[g]) begin
                  tmr_nxt[g] = tmr_r[g] + 19'h00001;
               end
               alarm_nxt[g] = start_r[g] && (tmr_r[g] + 19'h00001 >= dly[g]);
            end else begin
               start_nxt[g] = 1'b0;
               alarm_nxt[g] = 1'b0;
               tmr_nxt[g] = 19'h00000;
               blocked_nxt[g] = pickup_nxt[g] & blk_nxt;
            end
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         blk_r <= 1'b0;
         pickup_r <= 3'h0;
         start_r <= 3'h0;
         alarm_r <= 3'h0;
         blocked_r <= 3'h0;
         for (int g = 0; g < 3; g++) begin
            tmr_r[g] <= 19'h00000;
         end
      end else begin
         blk_r <= blk_nxt;
         pickup_r <= pickup_nxt;
         start_r <= start_nxt;
         alarm_r <= alarm_nxt;
         blocked_r <= blocked_nxt;
         for (int g = 0; g < 3; g++) begin
            tmr_r[g] <= tmr_nxt[g];
         end
      end
   end

   // ========================================
   // Status, events, counters, log
   logic        blkAny, blkAnyPrev_r;
   logic [2:0]  startPrev_r, alarmPrev_r;
   logic [13:0] onEdge, offEdge, pend_r, pend_nxt;
   logic [15:0] sCnt_nxt, aCnt_nxt, bCnt_nxt;
   hdm_pkg::hdm_state_t st_nxt;
   hdm_pkg::hdm_evt_t   evt_nxt;
   logic                evtV_nxt;
   logic [3:0]          wrPtr_r, wrPtr_nxt, fill_nxt;
   hdm_pkg::hdm_log_t   logMem [hdm_pkg::LOG_DEPTH];
   hdm_pkg::hdm_log_t   logEntry;
   logic                logWr;
   logic [3:0]          logCode;

   always_comb begin
      blkAny = |blocked_r;
      onEdge = 14'h0000;
      offEdge = 14'h0000;
      for (int g = 0; g < 3; g++) begin
         onEdge[2*g] = start_r[g] & ~startPrev_r[g];
         offEdge[2*g+1] = ~start_r[g] & startPrev_r[g];
         onEdge[6+2*g] = alarm_r[g] & ~alarmPrev_r[g];
         offEdge[7+2*g] = ~alarm_r[g] & alarmPrev_r[g];
      end
      onEdge[12] = blkAny & ~blkAnyPrev_r;
      offEdge[13] = ~blkAny & blkAnyPrev_r;
      // ON select masks even slots, OFF select masks odd slots
      pend_nxt = pend_r | (onEdge & selOn) | (offEdge & selOff);
      evtV_nxt = evtValid & ~evtReady;
      evt_nxt = evtData;
      if (!evtV_nxt) begin
         for (int i = 13; i >= 0; i--) begin
            if (pend_nxt[i]) begin
               evt_nxt.code = hdm_pkg::hdm_event_t'(4'(i));
               evt_nxt.stamp = timeNow;
               evtV_nxt = 1'b1;
            end
         end
         if (evtV_nxt) begin
            pend_nxt[evt_nxt.code] = 1'b0;
         end
      end
      // Alarm outranks start, start outranks blocked
      if (|alarm_r) begin
         st_nxt = hdm_pkg::ST_ALARM;
      end else if (|start_r) begin
         st_nxt = hdm_pkg::ST_START;
      end else if (blkAny) begin
         st_nxt = hdm_pkg::ST_BLOCKED;
      end else begin
         st_nxt = hdm_pkg::ST_NORMAL;
      end
      sCnt_nxt = startCount + 16'(($countones(onEdge[5:0])));
      aCnt_nxt = alarmCount + 16'(($countones(onEdge[11:6])));
      bCnt_nxt = blockedCount + 16'(onEdge[12]);
      if (counterClear) begin
         sCnt_nxt = 16'h0000;
         aCnt_nxt = 16'h0000;
         bCnt_nxt = 16'h0000;
      end
      logWr = |onEdge;
      logCode = 4'h0;
      for (int i = 12; i >= 0; i--) begin
         if (onEdge[i]) begin
            logCode = 4'(i);
         end
      end
      logEntry.stamp = timeNow;
      logEntry.code = hdm_pkg::hdm_event_t'(logCode);
      logEntry.thdL1 = meas.thdL1;
      logEntry.thdL2 = meas.thdL2;
      logEntry.thdL3 = meas.thdL3;
      logEntry.setGroup = setGroup;
      wrPtr_nxt = wrPtr_r;
      fill_nxt = logFill;
      if (logWr) begin
         wrPtr_nxt = (wrPtr_r == 4'(hdm_pkg::LOG_DEPTH - 1)) ? 4'h0 : wrPtr_r + 4'h1;
         if (logFill != 4'(hdm_pkg::LOG_DEPTH)) fill_nxt = logFill + 4'h1;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         startPrev_r <= 3'h0;
         alarmPrev_r <= 3'h0;
         blkAnyPrev_r <= 1'b0;
         pend_r <= 14'h0000;
         evtValid <= 1'b0;
         evtData <= '0;
         status <= hdm_pkg::ST_NORMAL;
         startCount <= 16'h0000;
         alarmCount <= 16'h0000;
         blockedCount <= 16'h0000;
         wrPtr_r <= 4'h0;
         logFill <= 4'h0;
         logData <= '0;
         startOut <= 3'h0;
         alarmOut <= 3'h0;
         blockedOut <= 1'b0;
         cycleTick <= 1'b0;
      end else begin
         startPrev_r <= start_r;
         alarmPrev_r <= alarm_r;
         blkAnyPrev_r <= blkAny;
         pend_r <= pend_nxt;
         evtValid <= evtV_nxt;
         evtData <= evt_nxt;
         status <= st_nxt;
         startCount <= sCnt_nxt;
         alarmCount <= aCnt_nxt;
         blockedCount <= bCnt_nxt;
         wrPtr_r <= wrPtr_nxt;
         logFill <= fill_nxt;
         logData <= (logIndex < 4'(hdm_pkg::LOG_DEPTH)) ? logMem[logIndex] : '0;
         startOut <= start_r;
         alarmOut <= alarm_r;
         blockedOut <= blkAny;
         cycleTick <= tick_r;
      end
   end

   // ========================================
   // Log storage, written on any ON edge
   always_ff @(posedge clk) begin
      if (logWr) begin
         logMem[wrPtr_r] <= logEntry;
      end
   end
endmodule : hdm_monitor
`default_nettype wire

// File: verification/hdm_monitor_sva.sv
`default_nettype none
module hdm_monitor_sva (
   input wire logic                clk,
   input wire logic                rst,
   input wire logic                evtReady,
   input wire logic                counterClear,
   input wire logic [2:0]          startOut,
   input wire logic [2:0]          alarmOut,
   input wire logic                blockedOut,
   input wire hdm_pkg::hdm_state_t status,
   input wire logic                evtValid,
   input wire hdm_pkg::hdm_evt_t   evtData,
   input wire logic [15:0]         startCount,
   input wire logic [3:0]          logFill,
   input wire logic                cycleTick
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   // ========================================
   // Group outputs
   a_tick_pulse: assert property (cycleTick |=> !cycleTick [*8]) else $error("tick too long");
   a_outs_on_tick: assert property (!$past(cycleTick) |-> $stable({startOut, alarmOut, blockedOut}))
      else $error("group output moved off tick");
   a_alarm_start: assert property ((alarmOut & ~startOut) == 3'h0) else $error("alarm without start");
   a_blocked_idle: assert property (blockedOut |-> startOut == 3'h0) else $error("start while blocked");
   a_status_map: assert property ((status == hdm_pkg::ST_ALARM) == (alarmOut != 3'h0))
      else $error("status disagrees with alarm");
   // ========================================
   // Events, counters, log
   a_evt_hold: assert property (evtValid && !evtReady |=> evtValid && $stable(evtData))
      else $error("event dropped while stalled");
   a_count_clear: assert property (counterClear |=> startCount == 16'h0) else $error("count not cleared");
   a_count_step: assert property ($changed(startCount) && !$past(counterClear) |->
      startCount == $past(startCount) + 16'h1) else $error("count jumped");
   a_log_bound: assert property (logFill <= 4'hc) else $error("log overfilled");
   c_alarm: cover property (alarmOut != 3'h0);
   c_blocked: cover property (blockedOut);
   c_stall: cover property (evtValid && !evtReady);
endmodule : hdm_monitor_sva
bind hdm_monitor hdm_monitor_sva i_sva (.clk, .rst, .evtReady, .counterClear, .startOut, .alarmOut,
   .blockedOut, .status, .evtValid, .evtData, .startCount, .logFill, .cycleTick);
`default_nettype wire

// File: verification/hdm_evt_sink.sv
`default_nettype none
module hdm_evt_sink (
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire logic              evtValid,
   input  wire hdm_pkg::hdm_evt_t evtData,
   output var logic               evtReady
);
   timeunit 1ns;
   timeprecision 1ns;
   hdm_pkg::hdm_evt_t got[$];
   logic [1:0]        stall_r;
   // Ready three cycles of four, so events wait now and then
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         stall_r  <= 2'h0;
         evtReady <= 1'b0;
      end else begin
         stall_r  <= stall_r + 2'h1;
         evtReady <= (stall_r != 2'h0);
         if (evtValid && evtReady) got.push_back(evtData);
      end
   end
endmodule : hdm_evt_sink
`default_nettype wire

// File: verification/testbench.sv
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic                clk = 1'b0, rst = 1'b1, blockIn = 1'b0, usePower = 1'b0, counterClear = 1'b0;
   hdm_pkg::hdm_meas_t  measAmpl = '0, measPower = '0, m;
   logic [2:0]          enable = 3'h7, setGroup = 3'h0, grp1, startOut, alarmOut;
   logic [15:0]         pu = hdm_pkg::PICKUP_DEFAULT, startCount, alarmCount, blockedCount;
   logic [18:0]         delayPhase = 19'h00001, delayLong = hdm_pkg::DELAY_DEFAULT;
   logic [13:0]         selOn = 14'h3fff, selOff = 14'h3ffd;
   logic [47:0]         timeNow = 48'h0, stamp1;
   logic [3:0]          logIndex = 4'h0, logFill, expCode[6] = '{4'h0, 4'h6, 4'h7, 4'hc, 4'h2, 4'hd};
   logic                evtReady, blockedOut, evtValid, cycleTick;
   hdm_pkg::hdm_state_t status;
   hdm_pkg::hdm_evt_t   evtData;
   hdm_pkg::hdm_log_t   logData;
   logic [31:0]         seed = 32'h00000063;
   logic [2:0]          startT[1:6] = '{3'h1, 3'h1, 3'h1, 3'h0, 3'h0, 3'h2};
   logic [2:0]          alarmT[1:6] = '{3'h0, 3'h1, 3'h1, 3'h0, 3'h0, 3'h0};
   logic [1:0]          stT[1:6] = '{2'h1, 2'h2, 2'h2, 2'h0, 2'h3, 2'h1};
   int                  mismatches = 0, checked = 0;
   always #25 clk = ~clk;
   hdm_monitor #(.CycleClks(200)) i_hdm_monitor (.clk, .rst, .blockIn, .measAmpl, .measPower, .usePower, .enable,
      .pickupPhase(pu), .pickupRes1(pu), .pickupRes2(pu), .delayPhase, .delayRes1(delayLong),
      .delayRes2(delayLong), .selOn, .selOff, .timeNow, .setGroup, .counterClear, .logIndex, .evtReady,
      .startOut, .alarmOut, .blockedOut, .status, .evtValid, .evtData, .startCount, .alarmCount,
      .blockedCount, .logData, .logFill, .cycleTick);
   hdm_evt_sink i_sink (.clk, .rst, .evtValid, .evtData, .evtReady);
   function automatic logic [31:0] xs(input logic [31:0] v);
      v ^= v << 13;
      v ^= v >> 17;
      v ^= v << 5;
      return v;
   endfunction : xs
   function automatic logic [15:0] hold97(input logic [15:0] s);
      return 16'((32'(s) * 97) / 100);
   endfunction : hold97
   task automatic check(input string what, input logic [47:0] exp, input logic [47:0] got);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : end_of_test
   task automatic tick();
      int n;
      n = 0;
      while (cycleTick !== 1'b1 && n < 400) begin
         @(negedge clk);
         n++;
      end
      if (n >= 400) begin
         mismatches++;
         end_of_test();
      end
      repeat (10) @(posedge clk);
   endtask : tick
   // ========================================
   // Steps: start, alarm, hold at 97 percent, release, blocked, clear
   initial begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      for (int s = 1; s <= 6; s++) begin
         seed = xs(seed);
         m.thdL1 = 16'(seed % 900);
         m.thdL3 = 16'(seed[31:8] % 900);
         m.thdRes2 = 16'(seed[31:12] % 900);
         m.thdL2 = (s <= 2) ? pu + 16'h1 : (s == 3) ? hold97(pu) : hold97(pu) - 16'h1;
         m.thdRes1 = (s >= 5) ? pu + 16'h1 : 16'(seed[31:16] % 900);
         usePower <= (s == 3);
         measAmpl <= (s == 3) ? '1 : m;
         measPower <= (s == 3) ? m : '1;
         timeNow <= {16'h0, seed};
         setGroup <= seed[2:0];
         blockIn <= (s == 5);
         counterClear <= (s == 6);
         if (s == 1) stamp1 = {16'h0, seed};
         if (s == 1) grp1 = seed[2:0];
         if (s == 3) begin
            repeat (2) @(posedge clk);
            blockIn <= 1'b1;
            repeat (5) @(posedge clk);
            blockIn <= 1'b0;
         end
         tick();
         check("startOut", startT[s], startOut);
         check("alarmOut", alarmT[s], alarmOut);
         check("blockedOut", s == 5, blockedOut);
         check("status", stT[s], status);
         check("startCount", (s == 6) ? 48'h0 : 48'h1, startCount);
         check("alarmCount", (s >= 2 && s <= 5) ? 48'h1 : 48'h0, alarmCount);
         check("blockedCount", s == 5, blockedCount);
         $display("step %0d done", s);
      end
      counterClear <= 1'b0;
      repeat (3) @(posedge clk);
      check("logFill", 48'h4, logFill);
      check("logCode", hdm_pkg::EV_START_PH_ON, logData.code);
      check("logThd", pu + 16'h1, logData.thdL2);
      check("logStamp", stamp1, logData.stamp);
      check("logGroup", grp1, logData.setGroup);
      check("evtCount", 48'h6, i_sink.got.size());
      for (int i = 0; i < 6; i++) check("evtCode", expCode[i], i_sink.got[i].code);
      check("evtStamp", stamp1, i_sink.got[0].stamp);
      $display("log and events done");
      end_of_test();
   end
endmodule : testbench
`default_nettype wire
